/* File: rtl/scr_regs.sv */
// system register bank: identification, slot hold flags and pin configuration
`timescale 1ns/1ps
`default_nettype none
module scr_regs #(
    parameter logic [7:0] PART_CODE = 8'h5a,   // arbitrary value
    parameter logic [7:0] MASK_VERSION = 8'h00, // arbitrary value
    parameter int DATA_W = 32
) (
    // clock and reset
    input wire logic CLK,
    input wire logic SYS_RST,
    // register port behind the serial host port
    input wire logic [14:0] REG_ADDR,
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic [15:0] REG_WDATA,
    output logic [15:0] REG_RDATA,
    // conversion results and slot result registers
    input wire scr_pkg::scr_result_t RESULT_IN,
    output logic [scr_pkg::SLOT_COUNT*DATA_W-1:0] SLOT_DATA,
    output logic [scr_pkg::SLOT_COUNT-1:0] HOLD_FLAGS,
    // pins
    input wire logic [1:0] GPIO_IN,
    input wire logic [1:0] GPIO_SRC,
    output scr_pkg::scr_pin_ctl_t [1:0] GPIO_CTL,
    output logic [1:0] GPIO_RX,
    output logic [1:0] GPIO_SLEW,
    output logic [1:0] GPIO_DRIVE
);

    // ==========================================================
    // register storage
    logic [1:0] slew;
    logic [1:0] drive;
    logic [2:0] pin_func [2];
    logic [11:0] hold;
    logic [DATA_W-1:0] slot_res [scr_pkg::SLOT_COUNT];

    wire hit_id = (REG_ADDR == scr_pkg::ADDR_PART_ID);
    wire hit_cfg = (REG_ADDR == scr_pkg::ADDR_PIN_CFG);
    wire hit_hold = (REG_ADDR == scr_pkg::ADDR_HOLD);
    wire wr_cfg = REG_WR && hit_cfg;
    wire wr_hold = REG_WR && hit_hold;
    // slots 12 to 15 do not exist, so a result aimed there is dropped
    wire res_in_range = RESULT_IN.valid && (RESULT_IN.slot < 4'(scr_pkg::SLOT_COUNT));
    wire res_take = res_in_range && !hold[RESULT_IN.slot];
    wire [15:0] cfg_word = {slew, drive, 6'h00, pin_func[1], pin_func[0]};
    wire [15:0] id_word = {MASK_VERSION, PART_CODE};
    wire [15:0] next_rdata = hit_id ? id_word :
                             hit_cfg ? cfg_word :
                             hit_hold ? {4'h0, hold} : 16'h0000;

    // the id register has no write path at all, so writes to it fall away
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            REG_RDATA <= 16'h0000;
        end else if (REG_RD) begin
            REG_RDATA <= next_rdata;
        end
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            hold <= scr_pkg::HOLD_RESET;
        end else if (wr_hold) begin
            hold <= REG_WDATA[11:0];
        end
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            slew <= scr_pkg::SLEW_RESET;
            drive <= scr_pkg::DRIVE_RESET;
            pin_func[1] <= scr_pkg::PIN_FUNC_RESET;
            pin_func[0] <= scr_pkg::PIN_FUNC_RESET;
        end else if (wr_cfg) begin
            slew <= REG_WDATA[scr_pkg::SLEW_LSB +: 2];
            drive <= REG_WDATA[scr_pkg::DRIVE_LSB +: 2];
            pin_func[1] <= REG_WDATA[scr_pkg::PIN1_LSB +: 3];
            pin_func[0] <= REG_WDATA[scr_pkg::PIN0_LSB +: 3];
        end
    end

    // ==========================================================
    // slot result registers
    // a result that lands in the same cycle as the hold write sees the old flag
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            for (int i = 0; i < scr_pkg::SLOT_COUNT; i++) begin
                slot_res[i] <= '0;
            end
        end else if (res_take) begin
            slot_res[RESULT_IN.slot] <= RESULT_IN.data;
        end
    end

    always_comb begin
        for (int i = 0; i < scr_pkg::SLOT_COUNT; i++) begin
            SLOT_DATA[i*DATA_W +: DATA_W] = slot_res[i];
        end
    end
    assign HOLD_FLAGS = hold;

    // ==========================================================
    // pin function decode
    function automatic scr_pkg::scr_pin_ctl_t pin_ctl(input logic [2:0] f, input logic src);
        scr_pkg::scr_pin_ctl_t c;
        c = '{oe_n: 1'b1, out: 1'b0, pull_up: 1'b0, pull_down: 1'b0, ibuf_en: 1'b0};
        case (f)
            scr_pkg::PF_OFF: c.ibuf_en = 1'b0;
            scr_pkg::PF_INPUT: c.ibuf_en = 1'b1;
            scr_pkg::PF_OUT: begin
                c.oe_n = 1'b0;
                c.out = src;
            end
            scr_pkg::PF_OUT_INV: begin
                c.oe_n = 1'b0;
                c.out = !src;
            end
            scr_pkg::PF_PD, scr_pkg::PF_PD_INV: begin
                c.pull_down = 1'b1;
                c.ibuf_en = 1'b1;
            end
            default: begin
                c.pull_up = 1'b1;
                c.ibuf_en = 1'b1;
            end
        endcase
        return c;
    endfunction

    // inverted pull modes flip the level seen by the core; disabled pins read zero
    function automatic logic pin_rx(input logic [2:0] f, input logic pin);
        logic inv;
        inv = (f == scr_pkg::PF_PD_INV) || (f == scr_pkg::PF_PU_INV);
        return (f == scr_pkg::PF_OFF) ? 1'b0 : (pin ^ inv);
    endfunction

    scr_pkg::scr_pin_ctl_t next_ctl [2];
    logic [1:0] next_rx;
    assign next_ctl[0] = pin_ctl(pin_func[0], GPIO_SRC[0]);
    assign next_ctl[1] = pin_ctl(pin_func[1], GPIO_SRC[1]);
    assign next_rx[0] = pin_rx(pin_func[0], GPIO_IN[0]);
    assign next_rx[1] = pin_rx(pin_func[1], GPIO_IN[1]);

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            GPIO_CTL <= {2{scr_pkg::PIN_CTL_RESET}};
            GPIO_RX <= 2'h0;
        end else begin
            GPIO_CTL[0] <= next_ctl[0];
            GPIO_CTL[1] <= next_ctl[1];
            GPIO_RX <= next_rx;
        end
    end
    assign GPIO_SLEW = slew;
    assign GPIO_DRIVE = drive;

    // ==========================================================
    // assertions
    default clocking cb @(posedge CLK); endclocking
    default disable iff (SYS_RST);

    a_hold_write: assert property (wr_hold |=> hold == $past(REG_WDATA[11:0]))
        else $error("hold flags not written");
    a_hold_reset: assert property ($fell(SYS_RST) |-> hold == 12'h000)
        else $error("hold flags not zero after reset");
    a_held_frozen: assert property (res_in_range && hold[RESULT_IN.slot]
        |=> slot_res[$past(RESULT_IN.slot)] == $past(slot_res[RESULT_IN.slot]))
        else $error("held slot changed");
    a_free_update: assert property (res_take
        |=> slot_res[$past(RESULT_IN.slot)] == $past(RESULT_IN.data))
        else $error("free slot missed result");
    a_slot_dropped: assert property (RESULT_IN.valid && !res_in_range |=> $stable(SLOT_DATA))
        else $error("result for a missing slot landed");
    // pin checks look one cycle on because the controls are registered
    a_pin1_output: assert property (pin_func[1] == scr_pkg::PF_OUT_INV && !wr_cfg
        |=> !GPIO_CTL[1].oe_n && GPIO_CTL[1].out == !$past(GPIO_SRC[1]))
        else $error("pin 1 inverted output wrong");
    a_pin1_off: assert property (pin_func[1] == scr_pkg::PF_OFF |=> GPIO_CTL[1].oe_n && !GPIO_CTL[1].ibuf_en)
        else $error("disabled pin 1 not floating");
    a_slew_field: assert property (wr_cfg |=> GPIO_SLEW == $past(REG_WDATA[15:14]))
        else $error("slew not taken");
    a_drive_field: assert property (wr_cfg |=> GPIO_DRIVE == $past(REG_WDATA[13:12]))
        else $error("drive not taken");
    a_pin0_pull: assert property (pin_func[0] == scr_pkg::PF_PD_INV
        |=> GPIO_CTL[0].pull_down && GPIO_CTL[0].oe_n && GPIO_RX[0] == !$past(GPIO_IN[0]))
        else $error("pin 0 pull mode wrong");
    a_id_read: assert property (REG_RD && hit_id |=> REG_RDATA == {MASK_VERSION, PART_CODE})
        else $error("id readback wrong");
    a_id_no_write: assert property (REG_WR && hit_id |=> $stable(cfg_word) && $stable(hold))
        else $error("write to id register changed another register");
    a_hold_read: assert property (REG_RD && hit_hold |=> REG_RDATA == {4'h0, $past(hold)})
        else $error("hold flags read back wrong");
    a_cfg_read: assert property (REG_RD && hit_cfg |=> REG_RDATA == $past(cfg_word))
        else $error("pin configuration read back wrong");
    a_pin1_input: assert property (pin_func[1] == scr_pkg::PF_INPUT
        |=> GPIO_CTL[1].oe_n && GPIO_CTL[1].ibuf_en && GPIO_RX[1] == $past(GPIO_IN[1]))
        else $error("pin 1 input mode wrong");
    a_pin1_pulldown: assert property (pin_func[1] == scr_pkg::PF_PD
        |=> GPIO_CTL[1].pull_down && !GPIO_CTL[1].pull_up && GPIO_CTL[1].oe_n)
        else $error("pin 1 pull-down mode wrong");
    a_pin0_output: assert property (pin_func[0] == scr_pkg::PF_OUT
        |=> !GPIO_CTL[0].oe_n && GPIO_CTL[0].out == $past(GPIO_SRC[0]))
        else $error("pin 0 normal output wrong");
    a_pin0_pullup: assert property (pin_func[0] == scr_pkg::PF_PU_INV
        |=> GPIO_CTL[0].pull_up && GPIO_CTL[0].oe_n && GPIO_RX[0] == !$past(GPIO_IN[0]))
        else $error("pin 0 inverted pull-up wrong");
    a_slew_steady: assert property (!wr_cfg |=> $stable(GPIO_SLEW))
        else $error("slew changed without a write");
    a_drive_steady: assert property (!wr_cfg |=> $stable(GPIO_DRIVE))
        else $error("drive changed without a write");

    // ==========================================================
    // scenarios worth seeing
    c_hold_block: cover property (RESULT_IN.valid && hold[RESULT_IN.slot]);
    c_free_write: cover property (RESULT_IN.valid && !hold[RESULT_IN.slot]);
    c_cfg_read: cover property (wr_cfg ##1 REG_RD && hit_cfg);
    c_id_write: cover property (REG_WR && hit_id);
    c_pin0_inv_pull: cover property (pin_func[0] == scr_pkg::PF_PU_INV && GPIO_IN[0]);

endmodule
`default_nettype wire

/* File: inc/scr_pkg.sv */
// package of offsets, field layouts, reset values and carrier types for the system register bank
// How it works
// - twelve read/write slot hold flags, reset zero
// - held slot keeps its result data
// - unheld slot takes each new result
// - pin 1 function field selects pin behaviour
// - two-bit slew setting for all pins
// - two-bit drive setting for all pins
// - pin 0 field uses same encoding
package scr_pkg;

    // ==========================================================
    // register map (word offsets on the host port)
    localparam logic [14:0] ADDR_PART_ID = 15'h0008;
    localparam logic [14:0] ADDR_PIN_CFG = 15'h0022;
    localparam logic [14:0] ADDR_HOLD = 15'h002e;

    // ==========================================================
    // field positions
    localparam int SLEW_LSB = 14;
    localparam int DRIVE_LSB = 12;
    localparam int PIN1_LSB = 3;
    localparam int PIN0_LSB = 0;
    localparam int VERSION_LSB = 8;
    localparam int SLOT_COUNT = 12;

    // ==========================================================
    // reset values
    localparam logic [1:0] SLEW_RESET = 2'h0;
    localparam logic [1:0] DRIVE_RESET = 2'h0;
    localparam logic [2:0] PIN_FUNC_RESET = 3'h0;
    localparam logic [11:0] HOLD_RESET = 12'h000;

    // ==========================================================
    // pin function codes
    localparam logic [2:0] PF_OFF = 3'h0;
    localparam logic [2:0] PF_INPUT = 3'h1;
    localparam logic [2:0] PF_OUT = 3'h2;
    localparam logic [2:0] PF_OUT_INV = 3'h3;
    localparam logic [2:0] PF_PD = 3'h4;
    localparam logic [2:0] PF_PD_INV = 3'h5;
    localparam logic [2:0] PF_PU = 3'h6;
    localparam logic [2:0] PF_PU_INV = 3'h7;

    // one new conversion result for a slot
    typedef struct packed {
        logic valid;
        logic [3:0] slot;
        logic [31:0] data;
    } scr_result_t;

    // electrical controls of one pin
    typedef struct packed {
        logic oe_n;
        logic out;
        logic pull_up;
        logic pull_down;
        logic ibuf_en;
    } scr_pin_ctl_t;

    // pin controls while reset: not driven, no pull, input buffer off
    localparam scr_pin_ctl_t PIN_CTL_RESET =
        '{oe_n: 1'b1, out: 1'b0, pull_up: 1'b0, pull_down: 1'b0, ibuf_en: 1'b0};

endpackage

/* File: sim/scr_regs_tb.sv */
// self-checking testbench for the system register bank
`timescale 1ns/1ps
`default_nettype none
module scr_regs_tb;
    // ==========================================================
    // stimulus and observed signals
    localparam logic [7:0] PART = 8'h3c; // arbitrary value
    localparam logic [7:0] VER = 8'h01; // arbitrary value
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [14:0] addr = 15'h0000;
    logic [15:0] wdata = 16'h0000;
    logic [15:0] rdata;
    scr_pkg::scr_result_t res = '0;
    logic [scr_pkg::SLOT_COUNT*32-1:0] sd;
    logic [11:0] hold;
    logic [11:0] hm = 12'h000;
    logic [1:0] gin = 2'h0;
    logic [1:0] gsrc = 2'h0;
    logic [1:0] grx, gslew, gdrv, sl, dr;
    scr_pkg::scr_pin_ctl_t [1:0] gctl;
    logic [31:0] em [12] = '{default: 32'h0000_0000};
    logic [2:0] c;
    int bad_count = 0;
    int total_checks = 0;
    int cyc = 0;

    always #12.5 clk = ~clk;

    scr_regs #(.PART_CODE(PART), .MASK_VERSION(VER), .DATA_W(32)) dut (
        .CLK(clk), .SYS_RST(rst), .REG_ADDR(addr), .REG_WR(wr), .REG_RD(rd), .REG_WDATA(wdata),
        .REG_RDATA(rdata), .RESULT_IN(res), .SLOT_DATA(sd), .HOLD_FLAGS(hold), .GPIO_IN(gin),
        .GPIO_SRC(gsrc), .GPIO_CTL(gctl), .GPIO_RX(grx), .GPIO_SLEW(gslew), .GPIO_DRIVE(gdrv)
    );

    // ==========================================================
    // shared tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic give_verdict();
        if (bad_count == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic wreg(input logic [14:0] a, input logic [15:0] d);
        @(negedge clk);
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(negedge clk);
        wr = 1'b0;
    endtask

    // read data is registered, so it is looked at one cycle after the strobe
    task automatic rchk(input logic [14:0] a, input logic [15:0] exp);
        @(negedge clk);
        addr = a;
        rd = 1'b1;
        @(negedge clk);
        rd = 1'b0;
        chk(rdata, exp);
    endtask

    // output drive and receive value are only defined for some codes
    task automatic pin_chk(input logic [2:0] f, input scr_pkg::scr_pin_ctl_t g, input logic s, input logic i,
                           input logic x);
        logic drv;
        drv = f inside {scr_pkg::PF_OUT, scr_pkg::PF_OUT_INV};
        chk(g.oe_n, !drv);
        chk({g.pull_up, g.pull_down}, {f[2] & f[1], f[2] & ~f[1]});
        if (drv) begin
            chk(g.out, s ^ f[0]);
        end else begin
            chk({g.ibuf_en, x}, {f != 3'h0, (f != 3'h0) & (i ^ (f[2] & f[0]))});
        end
    endtask

    always @(posedge clk) begin
        cyc++;
        if (cyc > 5000) begin
            bad_count++;
            give_verdict();
        end
    end

    initial begin
        void'($urandom(32'h132cbb53));
        repeat (4) @(negedge clk);
        rst = 1'b0;
        rchk(scr_pkg::ADDR_PART_ID, {VER, PART});
        rchk(scr_pkg::ADDR_HOLD, 16'h0000);
        rchk(scr_pkg::ADDR_PIN_CFG, 16'h0000);
        for (int p = 0; p < 2; p++) pin_chk(3'h0, gctl[p], gsrc[p], gin[p], grx[p]);
        wreg(scr_pkg::ADDR_PART_ID, 16'hffff);
        rchk(scr_pkg::ADDR_PART_ID, {VER, PART});
        rchk(15'h0009, 16'h0000);
        // results race hold writes in the same cycle: the old flag decides
        for (int n = 0; n < 400; n++) begin
            @(negedge clk);
            for (int s = 0; s < 12; s++) chk(sd[s*32 +: 32], em[s]);
            chk(hold, hm);
            wr = ($urandom % 5) == 0;
            addr = scr_pkg::ADDR_HOLD;
            wdata = 16'($urandom);
            res = {($urandom % 4) != 0, 4'($urandom % 14), 32'($urandom)};
            if (res.valid && res.slot < 12 && !hm[res.slot]) em[res.slot] = res.data;
            if (wr) hm = wdata[11:0];
        end
        @(negedge clk);
        wr = 1'b0;
        res = '0;
        rchk(scr_pkg::ADDR_HOLD, {4'h0, hm});
        wreg(scr_pkg::ADDR_HOLD, 16'hffff);
        rchk(scr_pkg::ADDR_HOLD, 16'h0fff);
        for (int k = 0; k < 16; k++) begin
            c = k[2:0];
            sl = 2'($urandom);
            dr = 2'($urandom);
            wreg(scr_pkg::ADDR_PIN_CFG, {sl, dr, 6'($urandom), c, ~c});
            gsrc = 2'($urandom);
            gin = 2'($urandom);
            repeat (2) @(negedge clk);
            chk({gslew, gdrv}, {sl, dr});
            for (int p = 0; p < 2; p++) pin_chk(p ? c : ~c, gctl[p], gsrc[p], gin[p], grx[p]);
            rchk(scr_pkg::ADDR_PIN_CFG, {sl, dr, 6'h00, c, ~c});
        end
        give_verdict();
    end
endmodule
`default_nettype wire
